/* File: verilog/msi_master_selector.sv */
// Purpose: Interrupt status, reset defaults and target logic of a 2-to-1
//          master selector
// Assumes: Upstream and downstream pins are open drain, resolved outside
// Notes:   Recovery pulses run on linkClk; the rest runs on core_clk
//
// Summary of operation
// - Status reads leave the test flags and downstream flag untouched.
// - Downstream flag clears only once the interrupt input is high again.
// - Self-test flag clears when the same controller writes its request zero.
// - Peer-test flag clears when the other controller writes its request zero.
// - Interrupt output releases once the test request behind it is cleared.
// - Recovery, sensor and lost flags clear on second clock of a status register read.
// - Interrupt input still low after a read raises the flag again.
// - Power-on reset holds defaults; release loads default register values.
// - Channel-0 variant connects channel 0 after reset without waiting.
// - No-channel variant stays disconnected after reset awaiting a control register write.
// - Control register writes set the connection from the writing controller's control register.
// - Low reset pin holds registers and target state at defaults.
// - SDA changes while SCL is high are conditions, never data.
// - SDA fall with SCL high is START, rise is STOP.
// - Each byte is followed by one acknowledge bit clocked by controller.
// - Target acknowledges each received byte but the third written one by holding SDA low.
// - Unacknowledged read byte ends the read; target releases SDA.
// - A third written data byte is not acknowledged.
// - Fourth byte of a continued read returns the first register.
// - On command, nine clocks and STOP are sent before reconnecting.
// - Each controller has its own status register copy.
// - Low interrupt input pulls both outputs low unless masked.
`timescale 1ns/100ps
`default_nettype none

module msi_i2c_slave
  import msi_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Upstream bus pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOe,
  // Register access
  input  wire logic [6:0] devAddr,
  input  wire logic [7:0] rdData,
  output logic            wrStb,
  output logic [7:0]      wrData,
  output logic [1:0]      ptr,
  output logic            statClr
);

  logic [2:0]  sclSy;
  logic [2:0]  sdaSy;
  logic        sclRise;
  logic        sclFall;
  logic        startC;
  logic        stopC;
  msi_i2c_st_t st;
  logic [2:0]  bitCnt;
  logic [7:0]  shReg;
  logic [1:0]  byteIdx;
  logic        rnw;
  logic        ackHalf;

  // Two sync stages plus one history stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclSy <= 3'h7;
      sdaSy <= 3'h7;
    end else begin
      sclSy <= {sclSy[1:0], sclIn};
      sdaSy <= {sdaSy[1:0], sdaIn};
    end
  end

  // Clock edges and bus conditions
  assign sclRise = sclSy[1] & ~sclSy[2];
  assign sclFall = ~sclSy[1] & sclSy[2];
  assign startC  = sclSy[1] & sclSy[2] & sdaSy[2] & ~sdaSy[1];
  assign stopC   = sclSy[1] & sclSy[2] & ~sdaSy[2] & sdaSy[1];

  // Transfer sequencing; SDA is sampled on rise and driven on fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st      <= ST_IDLE;
      bitCnt  <= 3'h0;
      shReg   <= 8'h00;
      byteIdx <= 2'h0;
      rnw     <= 1'b0;
      ackHalf <= 1'b0;
      ptr     <= REG_MASK;
      sdaOe   <= 1'b0;
      wrStb   <= 1'b0;
      wrData  <= 8'h00;
      statClr <= 1'b0;
    end else begin
      wrStb   <= 1'b0;
      statClr <= 1'b0;
      if (stopC) begin
        st    <= ST_IDLE;
        sdaOe <= 1'b0;
      end else if (startC) begin
        st      <= ST_ADDR;
        bitCnt  <= 3'h0;
        byteIdx <= 2'h0;
        ackHalf <= 1'b0;
        sdaOe   <= 1'b0;
      end else begin
        unique case (st)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (sclRise) begin
              shReg  <= {shReg[6:0], sdaSy[1]};
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == 3'h7) begin
                rnw <= sdaSy[1];
                st  <= (shReg[6:0] == devAddr) ? ST_ACK : ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              ackHalf <= ~ackHalf;
              if (!ackHalf) begin
                sdaOe <= 1'b1;
              end else if (rnw) begin
                st     <= ST_RD;
                shReg  <= rdData;
                sdaOe  <= ~rdData[7];
                bitCnt <= 3'h0;
              end else begin
                st     <= ST_WR;
                sdaOe  <= 1'b0;
                bitCnt <= 3'h0;
              end
            end
          end
          ST_WR: begin
            if (sclRise) begin
              shReg  <= {shReg[6:0], sdaSy[1]};
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == 3'h7) begin
                byteIdx <= byteIdx + 2'h1;
                if (byteIdx == 2'h0) begin
                  ptr <= {shReg[0], sdaSy[1]};
                end
                if (byteIdx == 2'h1) begin
                  wrStb  <= 1'b1;
                  wrData <= {shReg[6:0], sdaSy[1]};
                end
                st <= (byteIdx == 2'h2) ? ST_IDLE : ST_ACK;
              end
            end
          end
          ST_RD: begin
            if (sclRise && bitCnt == 3'h1 && ptr == REG_ISTAT) begin
              statClr <= 1'b1;
            end
            if (sclFall) begin
              if (bitCnt == 3'h7) begin
                st    <= ST_RDACK;
                sdaOe <= 1'b0;
                ptr   <= (ptr == REG_ISTAT) ? REG_MASK : ptr + 2'h1;
              end else begin
                shReg  <= {shReg[6:0], 1'b0};
                sdaOe  <= ~shReg[6];
                bitCnt <= bitCnt + 3'h1;
              end
            end
          end
          ST_RDACK: begin
            if (sclRise) begin
              ackHalf <= ~sdaSy[1];
            end
            if (sclFall) begin
              ackHalf <= 1'b0;
              if (ackHalf) begin
                st     <= ST_RD;
                shReg  <= rdData;
                sdaOe  <= ~rdData[7];
                bitCnt <= 3'h0;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end

endmodule : msi_i2c_slave

module msi_master_selector
  import msi_pkg::*;
#(
  parameter bit         DEFAULT_CH0 = 1'b1,
  parameter logic [6:0] DEV_ADDR    = DEV_ADDR_DEF
)(
  // Clocks and resets
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       linkClk,
  input  wire logic       extResetN,
  // Upstream buses, index is the channel
  input  wire logic [1:0] upSclIn,
  input  wire logic [1:0] upSdaIn,
  output logic [1:0]      upSdaO,
  output logic [1:0]      upSdaOe,
  // Upstream interrupt outputs, open drain
  output logic            upstreamIrqOut0O,
  output logic            upstreamIrqOut0Oe,
  output logic            upstreamIrqOut1O,
  output logic            upstreamIrqOut1Oe,
  // Downstream bus and interrupt input
  input  wire logic       dnSclIn,
  input  wire logic       dnSdaIn,
  output logic            dnSclO,
  output logic            dnSclOe,
  output logic            dnSdaO,
  output logic            dnSdaOe,
  input  wire logic       dnIrqInN,
  // Switch control
  output logic            connect0,
  output logic            connect1
);

  logic [1:0]      extSy;
  logic            extHold;
  logic            sysRst;
  logic [1:0]      intSy;
  logic            intInS;
  logic [2:0]      dnSclSy;
  logic [2:0]      dnSdaSy;
  logic            dnBusy;
  logic [1:0]      wrStb;
  logic [1:0][7:0] wrData;
  logic [1:0][1:0] ptr;
  logic [1:0]      statClr;
  logic [1:0][7:0] rdData;
  logic [1:0][7:0] maskReg;
  logic [1:0][7:0] ctrlReg;
  logic [1:0][7:0] statReg;
  logic [1:0]      ctlWr;
  logic [1:0]      ctlEvt;
  logic [1:0]      clrEvt;
  logic            cSel;
  logic [7:0]      cCtl;
  msi_conn_t       mine;
  msi_conn_t       owner;
  logic            recPend;
  logic            recFor;
  logic            reqTgl;
  logic [2:0]      doneSy;
  logic            doneEdge;
  logic [1:0]      evLost;
  logic [1:0]      evSensor;
  logic [1:0]      evRecov;
  logic [1:0]      irqSrc;
  logic [1:0]      irqOe;
  logic [2:0]      reqSy;
  logic            recBusy;
  logic [4:0]      recStep;
  logic            doneTgl;

  // External reset pin is synchronised and then held as a reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extSy   <= 2'h0;
      extHold <= 1'b1;
    end else begin
      extSy   <= {extSy[0], extResetN};
      extHold <= ~extSy[1];
    end
  end
  assign sysRst = rst | extHold;

  // Interrupt input and downstream line synchronisers
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) begin
      intSy   <= 2'h3;
      dnSclSy <= 3'h7;
      dnSdaSy <= 3'h7;
    end else begin
      intSy   <= {intSy[0], dnIrqInN};
      dnSclSy <= {dnSclSy[1:0], dnSclIn};
      dnSdaSy <= {dnSdaSy[1:0], dnSdaIn};
    end
  end
  assign intInS = intSy[1];

  // Bus sensor: busy between START and STOP on the downstream bus
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) begin
      dnBusy <= 1'b0;
    end else if (dnSclSy[1] & dnSclSy[2]) begin
      if (dnSdaSy[2] & ~dnSdaSy[1]) begin
        dnBusy <= 1'b1;
      end else if (~dnSdaSy[2] & dnSdaSy[1]) begin
        dnBusy <= 1'b0;
      end
    end
  end

  // One target per upstream channel
  for (genvar g = 0; g < 2; g++) begin : gSlv
    msi_i2c_slave uSlv (
      .core_clk (core_clk),
      .rst      (sysRst),
      .sclIn    (upSclIn[g]),
      .sdaIn    (upSdaIn[g]),
      .sdaOe    (upSdaOe[g]),
      .devAddr  (DEV_ADDR),
      .rdData   (rdData[g]),
      .wrStb    (wrStb[g]),
      .wrData   (wrData[g]),
      .ptr      (ptr[g]),
      .statClr  (statClr[g])
    );
  end
  assign upSdaO = 2'h0;

  // Read mux; each controller sees its own copy
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      unique case (ptr[c])
        REG_MASK:  rdData[c] = maskReg[c];
        REG_CTRL:  rdData[c] = ctrlReg[c];
        REG_ISTAT: rdData[c] = statReg[c];
        default:   rdData[c] = 8'h00;
      endcase
      ctlWr[c] = wrStb[c] && ptr[c] == REG_CTRL;
    end
  end

  // Mask and control registers per controller
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) begin
      maskReg <= {MASK_RST, MASK_RST};
      ctrlReg <= {CTRL_RST, CTRL_RST};
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wrStb[c] && ptr[c] == REG_MASK) maskReg[c] <= wrData[c];
        if (ctlWr[c]) ctrlReg[c] <= wrData[c];
      end
    end
  end

  // Status flags; a new event wins over a read clear
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) begin
      statReg <= {STAT_RST, STAT_RST};
    end else begin
      for (int c = 0; c < 2; c++) begin
        statReg[c][ST_SELF] <= ctrlReg[c][CTL_SELF];
        statReg[c][ST_PEER] <= ctrlReg[1-c][CTL_PEER];
        statReg[c][ST_DIRQ] <= ~intInS;
        if (evLost[c]) statReg[c][ST_LOST] <= 1'b1;
        else if (statClr[c]) statReg[c][ST_LOST] <= 1'b0;
        if (evSensor[c]) statReg[c][ST_SENSOR] <= 1'b1;
        else if (statClr[c]) statReg[c][ST_SENSOR] <= 1'b0;
        if (evRecov[c]) statReg[c][ST_RECOV] <= 1'b1;
        else if (statClr[c]) statReg[c][ST_RECOV] <= 1'b0;
      end
    end
  end

  // Unmasked flags pull the interrupt outputs low
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      irqSrc[c] = statReg[c][ST_SELF] | statReg[c][ST_PEER]
        | (statReg[c][ST_DIRQ] & ~maskReg[c][MSK_IN])
        | (statReg[c][ST_LOST] & ~maskReg[c][MSK_LOST])
        | (statReg[c][ST_SENSOR] & ~maskReg[c][MSK_SENSOR])
        | (statReg[c][ST_RECOV] & ~maskReg[c][MSK_RECOV]);
    end
  end
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) irqOe <= 2'h0;
    else irqOe <= irqSrc;
  end
  assign upstreamIrqOut0O  = 1'b0;
  assign upstreamIrqOut1O  = 1'b0;
  assign upstreamIrqOut0Oe = irqOe[0];
  assign upstreamIrqOut1Oe = irqOe[1];

  // Pending control writes; channel 0 is served first
  assign cSel     = ~ctlEvt[0];
  assign cCtl     = ctrlReg[cSel];
  assign mine     = cSel ? CONN_CH1 : CONN_CH0;
  assign clrEvt   = (!recPend && ctlEvt != 2'h0) ?
                    (cSel ? 2'b10 : 2'b01) : 2'h0;
  assign doneEdge = doneSy[1] ^ doneSy[2];

  // Done toggle from the link domain
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) doneSy <= 3'h0;
    else doneSy <= {doneSy[1:0], doneTgl};
  end

  // Connection control and switch events
  always_ff @(posedge core_clk or posedge sysRst) begin
    if (sysRst) begin
      owner    <= DEFAULT_CH0 ? CONN_CH0 : CONN_NONE;
      ctlEvt   <= 2'h0;
      recPend  <= 1'b0;
      recFor   <= 1'b0;
      reqTgl   <= 1'b0;
      evLost   <= 2'h0;
      evSensor <= 2'h0;
      evRecov  <= 2'h0;
    end else begin
      evLost   <= 2'h0;
      evSensor <= 2'h0;
      evRecov  <= 2'h0;
      ctlEvt   <= (ctlEvt & ~clrEvt) | ctlWr;
      if (recPend) begin
        if (doneEdge) begin
          recPend         <= 1'b0;
          owner           <= recFor ? CONN_CH1 : CONN_CH0;
          evRecov[recFor] <= 1'b1;
        end
      end else if (ctlEvt != 2'h0) begin
        if (cCtl[CTL_CONN] && owner != mine) begin
          if (owner != CONN_NONE) evLost[~cSel] <= 1'b1;
          if (cCtl[CTL_RECOV]) begin
            owner   <= CONN_NONE;
            recPend <= 1'b1;
            recFor  <= cSel;
            reqTgl  <= ~reqTgl;
          end else begin
            owner <= mine;
            if (dnBusy) evSensor[cSel] <= 1'b1;
          end
        end else if (!cCtl[CTL_CONN] && owner == mine) begin
          owner <= CONN_NONE;
        end
      end
    end
  end
  assign connect0 = owner[0];
  assign connect1 = owner[1];

  // Link domain: nine clocks with SDA released, then STOP
  always_ff @(posedge linkClk or posedge sysRst) begin
    if (sysRst) begin
      reqSy   <= 3'h0;
      recBusy <= 1'b0;
      recStep <= 5'h00;
      dnSclOe <= 1'b0;
      dnSdaOe <= 1'b0;
      doneTgl <= 1'b0;
    end else begin
      reqSy <= {reqSy[1:0], reqTgl};
      if (!recBusy) begin
        if (reqSy[2] != reqSy[1]) begin
          recBusy <= 1'b1;
          recStep <= 5'h00;
        end
      end else begin
        recStep <= recStep + 5'h01;
        if (recStep < REC_PULSE_END) begin
          dnSclOe <= ~recStep[0];
        end else if (recStep == REC_PULSE_END) begin
          dnSclOe <= 1'b1;
          dnSdaOe <= 1'b1;
        end else if (recStep == REC_SCL_UP) begin
          dnSclOe <= 1'b0;
        end else begin
          dnSdaOe <= 1'b0;
          recBusy <= 1'b0;
          doneTgl <= ~doneTgl;
        end
      end
    end
  end
  assign dnSclO = 1'b0;
  assign dnSdaO = 1'b0;

  // Checks
  self_flag_a: assert property (@(posedge core_clk) disable iff (sysRst)
    !ctrlReg[0][CTL_SELF] |=> !statReg[0][ST_SELF])
    else $error("self-test flag not cleared");
  peer_flag_a: assert property (@(posedge core_clk) disable iff (sysRst)
    1'b1 |=> statReg[0][ST_PEER] == $past(ctrlReg[1][CTL_PEER])
    && statReg[1][ST_PEER] == $past(ctrlReg[0][CTL_PEER]))
    else $error("peer-test flag does not follow other request");
  dirq_clear_a: assert property (@(posedge core_clk) disable iff (sysRst)
    intInS |=> !statReg[0][ST_DIRQ] && !statReg[1][ST_DIRQ])
    else $error("downstream flag stuck after input high");
  dirq_keep_a: assert property (@(posedge core_clk) disable iff (sysRst)
    !intInS && statClr[0] |=> statReg[0][ST_DIRQ])
    else $error("downstream flag lost on read");
  irq_unmask_a: assert property (@(posedge core_clk) disable iff (sysRst)
    statReg[1][ST_DIRQ] && !maskReg[1][MSK_IN] |=> irqOe[1])
    else $error("unmasked downstream flag not driving output");
  irq_release_a: assert property (@(posedge core_clk) disable iff (sysRst)
    irqSrc == 2'h0 |=> irqOe == 2'h0)
    else $error("interrupt output held without source");
  read_clear_a: assert property (@(posedge core_clk) disable iff (sysRst)
    statClr[0] && !evLost[0] |=> !statReg[0][ST_LOST])
    else $error("lost flag survives status read");
  conn_write_a: assert property (@(posedge core_clk) disable iff (sysRst)
    !recPend && ctlEvt == 2'b01 && ctrlReg[0][CTL_CONN]
    && !ctrlReg[0][CTL_RECOV] |=> owner == CONN_CH0)
    else $error("channel 0 not connected after write");
  stop_gen_a: assert property (@(posedge linkClk) disable iff (sysRst)
    recBusy && recStep == REC_SCL_UP |=> !dnSclOe && dnSdaOe
    ##1 !dnSdaOe && !recBusy)
    else $error("recovery does not end with STOP");

endmodule : msi_master_selector

`default_nettype wire

/* File: verilog/msi_pkg.sv */
// Purpose: Shared constants and types for the master selector interrupt block
// Assumes: Three registers per upstream controller, selected by a pointer
// Notes:   Pointer values double as register indices
`default_nettype none

package msi_pkg;

  // Register pointer values
  localparam logic [1:0] REG_MASK  = 2'h0;
  localparam logic [1:0] REG_CTRL  = 2'h1;
  localparam logic [1:0] REG_ISTAT = 2'h2;

  // Status register bit positions
  localparam int ST_PEER   = 7;
  localparam int ST_SELF   = 6;
  localparam int ST_LOST   = 3;
  localparam int ST_SENSOR = 2;
  localparam int ST_RECOV  = 1;
  localparam int ST_DIRQ   = 0;

  // Control register bit positions
  localparam int CTL_CONN  = 0;
  localparam int CTL_RECOV = 1;
  localparam int CTL_SELF  = 4;
  localparam int CTL_PEER  = 5;

  // Mask register bit positions
  localparam int MSK_IN     = 0;
  localparam int MSK_RECOV  = 1;
  localparam int MSK_SENSOR = 2;
  localparam int MSK_LOST   = 3;

  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;

  // Default target address, arbitrary value
  localparam logic [6:0] DEV_ADDR_DEF = 7'h70;

  // Recovery sequence steps on the link clock
  localparam logic [4:0] REC_PULSE_END = 5'h12;
  localparam logic [4:0] REC_SCL_UP    = 5'h13;

  // Downstream connection, one bit per channel
  typedef enum logic [1:0] {
    CONN_NONE = 2'b00,
    CONN_CH0  = 2'b01,
    CONN_CH1  = 2'b10
  } msi_conn_t;

  // Upstream target states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_WR    = 3'b011,
    ST_RD    = 3'b100,
    ST_RDACK = 3'b101
  } msi_i2c_st_t;

endpackage : msi_pkg

`default_nettype wire

/* File: dv/msi_ctrl_model.sv */
// Purpose: Behavioural upstream bus controller for the selector bench
// Assumes: Open-drain data line with pull-up; target pulls low via sdaOe
// Notes:   Lines change 1 ns after a core clock edge, HALF edges apart
`timescale 1ns/100ps
`default_nettype none

module msi_ctrl_model
  import msi_pkg::*;
#(
  parameter int HALF = 10
)(
  // Clock
  input  wire logic core_clk,
  // Bus lines
  input  wire logic sdaOe,
  output logic      sclLine,
  output logic      sdaLine
);
  logic sdaDrv;

  // Resolved data line, released level is high
  assign sdaLine = sdaDrv & ~sdaOe;

  // Idle bus, both lines high
  initial begin
    sclLine = 1'b1;
    sdaDrv  = 1'b1;
  end

  // Half a bit time
  task automatic hp();
    repeat (HALF) @(posedge core_clk);
    #1;
  endtask : hp

  // Only called on an idle bus
  task automatic start_cond();
    hp();
    sdaDrv = 1'b0;
    hp();
    sclLine = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    sdaDrv = 1'b0;
    hp();
    sclLine = 1'b1;
    hp();
    sdaDrv = 1'b1;
    hp();
  endtask : stop_cond

  // Data set while clock low, sampled at end of high
  task automatic bit_cyc(input logic d, output logic q);
    sdaDrv = d;
    hp();
    sclLine = 1'b1;
    hp();
    q = sdaLine;
    sclLine = 1'b0;
  endtask : bit_cyc

  // Eight bits then the acknowledge clock, MSB first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], q);
    bit_cyc(1'b1, q);
    ack = ~q;
  endtask : send_byte

  // Last byte is not acknowledged
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
    bit_cyc(last, q);
  endtask : recv_byte

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d,
                        input int n, output logic [3:0] acks);
    acks = 4'h0;
    start_cond();
    send_byte({DEV_ADDR_DEF, 1'b0}, acks[0]);
    send_byte(ptr, acks[1]);
    send_byte(d, acks[2]);
    if (n > 2) send_byte(8'hA5, acks[3]);
    stop_cond();
  endtask : wr_reg

  task automatic rd_regs(input logic [7:0] ptr, input int n,
                         output logic [31:0] d);
    logic a;
    d = 32'h0;
    start_cond();
    send_byte({DEV_ADDR_DEF, 1'b0}, a);
    send_byte(ptr, a);
    stop_cond();
    start_cond();
    send_byte({DEV_ADDR_DEF, 1'b1}, a);
    for (int k = 0; k < n; k++) recv_byte(k == n - 1, d[8*k +: 8]);
    stop_cond();
  endtask : rd_regs

endmodule : msi_ctrl_model

`default_nettype wire

/* File: dv/msi_master_selector_tb.sv */
// Purpose: Self-checking bench for the master selector status logic
// Assumes: Downstream lines have pull-ups; one model per upstream channel
// Notes:   A second instance covers the no-channel variant defaults
`timescale 1ns/100ps
`default_nettype none

module msi_master_selector_tb;
  import msi_pkg::*;

  logic            core_clk = 1'b0;
  logic            linkClk  = 1'b0;
  logic            rst, extResetN, dnIrqInN;
  wire logic [1:0] upScl, upSda;
  logic [1:0]      upSdaOe;
  logic            irq0Oe, irq1Oe, dnSclOe, dnSdaOe;
  logic [1:0]      upSdaO;
  logic            irq0O, irq1O, dnSclO, dnSdaO, dnSdaTb;
  logic            connect0, connect1, ncConn0, ncConn1;
  int              errors, check_count, pulses, connPulses, stops;

  // Clocks, unrelated in phase
  always #5 core_clk = ~core_clk;
  always #16 linkClk = ~linkClk;

  msi_master_selector u_msi_master_selector (
    .core_clk(core_clk), .rst(rst), .linkClk(linkClk),
    .extResetN(extResetN), .upSclIn(upScl), .upSdaIn(upSda),
    .upSdaO(upSdaO), .upSdaOe(upSdaOe),
    .upstreamIrqOut0O(irq0O), .upstreamIrqOut0Oe(irq0Oe),
    .upstreamIrqOut1O(irq1O), .upstreamIrqOut1Oe(irq1Oe),
    .dnSclIn(~dnSclOe), .dnSdaIn(~dnSdaOe & dnSdaTb), .dnSclO(dnSclO),
    .dnSclOe(dnSclOe), .dnSdaO(dnSdaO), .dnSdaOe(dnSdaOe),
    .dnIrqInN(dnIrqInN), .connect0(connect0), .connect1(connect1));

  msi_master_selector #(.DEFAULT_CH0(1'b0)) u_msi_master_selector_nc (
    .core_clk(core_clk), .rst(rst), .linkClk(linkClk),
    .extResetN(extResetN), .upSclIn(upScl), .upSdaIn(upSda),
    .upSdaO(), .upSdaOe(), .upstreamIrqOut0O(), .upstreamIrqOut0Oe(),
    .upstreamIrqOut1O(), .upstreamIrqOut1Oe(), .dnSclIn(1'b1),
    .dnSdaIn(1'b1), .dnSclO(), .dnSclOe(), .dnSdaO(), .dnSdaOe(),
    .dnIrqInN(dnIrqInN), .connect0(ncConn0), .connect1(ncConn1));

  msi_ctrl_model u_msi_ctrl_model_0 (.core_clk(core_clk),
    .sdaOe(upSdaOe[0]), .sclLine(upScl[0]), .sdaLine(upSda[0]));
  msi_ctrl_model u_msi_ctrl_model_1 (.core_clk(core_clk),
    .sdaOe(upSdaOe[1]), .sclLine(upScl[1]), .sdaLine(upSda[1]));

  // Pulses counted at SCL release, so the STOP step cannot race them
  always @(negedge dnSclOe) begin
    if (dnSdaOe === 1'b0) pulses++;
    if (connect0 | connect1) connPulses++;
  end
  always @(negedge dnSdaOe) if (dnSclOe === 1'b0) stops++;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input int ch, input logic [1:0] p, input logic [7:0] d);
    logic [3:0] a;
    if (ch == 0) u_msi_ctrl_model_0.wr_reg({6'h00, p}, d, 2, a);
    else u_msi_ctrl_model_1.wr_reg({6'h00, p}, d, 2, a);
    chk({5'h00, a[2:0]}, 8'h07, "write acks");
  endtask : wr

  task automatic rd(input int ch, input logic [1:0] p, input int n,
                    output logic [31:0] d);
    if (ch == 0) u_msi_ctrl_model_0.rd_regs({6'h00, p}, n, d);
    else u_msi_ctrl_model_1.rd_regs({6'h00, p}, n, d);
  endtask : rd

  function automatic logic [7:0] irqs();
    return {6'h00, irq1Oe, irq0Oe};
  endfunction : irqs

  task automatic t_self_peer();
    logic [31:0] d;
    wr(0, REG_CTRL, 8'h11);
    chk(irqs(), 8'h01, "self irq");
    rd(0, REG_ISTAT, 1, d);
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h40, "self flag kept");
    wr(0, REG_CTRL, 8'h01);
    chk(irqs(), 8'h00, "self irq off");
    wr(1, REG_CTRL, 8'h20);
    chk(irqs(), 8'h01, "peer irq");
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h80, "peer flag ch0");
    rd(1, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h00, "status ch1");
    wr(1, REG_CTRL, 8'h00);
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0] | irqs(), 8'h00, "peer cleared");
  endtask : t_self_peer

  task automatic t_dn_irq();
    logic [31:0] d;
    dnIrqInN = 1'b0;
    cyc(10);
    chk(irqs(), 8'h03, "both irq");
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h01, "input flag");
    chk(irqs(), 8'h03, "irq after read");
    wr(1, REG_MASK, 8'h01);
    chk(irqs(), 8'h01, "ch1 masked");
    dnIrqInN = 1'b1;
    cyc(10);
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0] | irqs(), 8'h00, "input flag off");
    wr(1, REG_MASK, 8'h00);
  endtask : t_dn_irq

  task automatic t_bytes_switch();
    logic [31:0] d;
    logic [3:0]  a;
    u_msi_ctrl_model_0.wr_reg(8'h00, 8'h0E, 3, a);
    chk({4'h0, a}, 8'h07, "third byte");
    rd(0, REG_MASK, 4, d);
    chk(d[7:0], 8'h0E, "byte 0");
    chk(d[15:8], 8'h01, "byte 1");
    chk(d[31:24], 8'h0E, "byte 3 wraps");
    wr(0, REG_MASK, 8'h00);
    wr(1, REG_CTRL, 8'h01);
    chk({6'h00, connect1, connect0}, 8'h02, "switch");
    chk(irqs(), 8'h01, "lost irq");
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h08, "lost flag");
    chk(irqs(), 8'h00, "lost cleared");
  endtask : t_bytes_switch

  task automatic t_recovery();
    logic [31:0] d;
    int          n;
    pulses = 0;
    connPulses = 0;
    stops = 0;
    wr(0, REG_CTRL, 8'h03);
    n = 0;
    while (connect0 !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk(pulses[7:0], 8'h09, "nine pulses");
    chk({stops[3:0], connPulses[3:0]}, 8'h10, "stop, no link");
    cyc(10);
    rd(0, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h02, "recovery flag");
    rd(1, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h08, "lost on ch1");
  endtask : t_recovery

  task automatic t_ext_reset();
    logic [31:0] d;
    extResetN = 1'b0;
    cyc(6);
    chk({2'h0, upSdaOe, connect1, connect0, irq1Oe, irq0Oe}, 8'h04,
        "pin reset");
    extResetN = 1'b1;
    cyc(10);
    rd(0, REG_CTRL, 1, d);
    chk(d[7:0], CTRL_RST, "ctrl default");
    dnSdaTb = 1'b0;
    wr(1, REG_CTRL, 8'h01);
    chk(irqs(), 8'h03, "busy switch irqs");
    rd(1, REG_ISTAT, 1, d);
    chk(d[7:0], 8'h04, "sensor flag");
    dnSdaTb = 1'b1;
  endtask : t_ext_reset

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Watchdog
  initial begin
    repeat (80000) @(posedge core_clk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    extResetN = 1'b1;
    dnIrqInN = 1'b1;
    dnSdaTb = 1'b1;
    cyc(6);
    rst = 1'b0;
    cyc(6);
    chk({4'h0, connect1, connect0, ncConn1, ncConn0}, 8'h04,
        "variants");
    chk({4'h0, upSdaOe, irq1Oe, irq0Oe}, 8'h00, "idle outputs");
    chk({2'h0, upSdaO, irq1O, irq0O, dnSclO, dnSdaO}, 8'h00, "lows");
    t_self_peer();
    t_dn_irq();
    t_bytes_switch();
    t_recovery();
    t_ext_reset();
    finish_test();
  end

endmodule : msi_master_selector_tb

`default_nettype wire
